// >>> gpbcd_board.sv
// Behavioural model of the board circuitry on one port's pins
`timescale 1ns/1ps
module gpbcd_board #(
    parameter int W = 8
) (
    // Clock
    input  wire logic [0:0]   clk_i,
    // Block pad side
    input  wire logic [W-1:0] drv_i,
    input  wire logic [W-1:0] oe_b_i,
    input  wire logic [W-1:0] pu_i,
    // External source on the board
    input  wire logic [W-1:0] ext_en_i,
    input  wire logic [W-1:0] ext_val_i,
    // Resolved pin level
    output logic [W-1:0]      lvl_o
);
    // Block drive, then board source, then pull-up; a floating pin wanders every cycle
    always_ff @(posedge clk_i) begin
        for (int i = 0; i < W; i++) begin
            lvl_o[i] <= !oe_b_i[i] ? drv_i[i] : ext_en_i[i] ? ext_val_i[i] : pu_i[i] ? 1'b1 : lvl_o[i] !== 1'b1;
        end
    end
endmodule // gpbcd_board

// >>> gpbcd_pkg.sv
// Package with register map, reset values and carrier types of the port B/C/D block
package gpbcd_pkg;

    // ------------------------------------------------------------
    // Register indices; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] GPBCD_IDX_B_DATA = 6'h01;
    localparam logic [5:0] GPBCD_IDX_C_DATA = 6'h02;
    localparam logic [5:0] GPBCD_IDX_D_DATA = 6'h03;
    localparam logic [5:0] GPBCD_IDX_B_DIR  = 6'h05;
    localparam logic [5:0] GPBCD_IDX_C_DIR  = 6'h06;
    localparam logic [5:0] GPBCD_IDX_D_DIR  = 6'h07;
    localparam logic [5:0] GPBCD_IDX_B_PUE  = 6'h09;
    localparam logic [5:0] GPBCD_IDX_C_PUE  = 6'h0a;
    localparam logic [5:0] GPBCD_IDX_D_PUE  = 6'h0b;

    // ------------------------------------------------------------
    // Field layout and reset values
    // ------------------------------------------------------------
    localparam int         GPBCD_C_IO_BITS   = 3;      // Port C bidirectional bits 2..0
    localparam int         GPBCD_C_BITS      = 4;      // Port C width, bit 3 input only
    localparam int         GPBCD_PORT_BITS   = 8;      // Port B and D width
    localparam int         GPBCD_PIN_BITS    = 20;     // All pins sampled together
    localparam logic [7:0] GPBCD_DIR_RST     = 8'h00;
    localparam logic [7:0] GPBCD_PUE_RST     = 8'h00;
    localparam logic [7:0] GPBCD_OE_B_RST    = 8'hff;
    localparam logic [7:0] GPBCD_PULL_RST    = 8'h00;

    // ------------------------------------------------------------
    // Carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [7:0] dir;                       // 1 = output
        logic [7:0] pue;                       // 1 = pull-up wanted
    } gpbcd_cfg_type;

    typedef struct packed {
        logic [7:0] oe_b;                      // Low while driving
        logic [7:0] pull;                      // Pull-up connected
    } gpbcd_pad_type;

endpackage : gpbcd_pkg

// >>> gpbcd_properties.sv
// Concurrent checks on the APB slave and pad outputs of the port B/C/D block
`timescale 1ns/1ps
module gpbcd_properties
    import gpbcd_pkg::*;
(
    // Clock, reset and enable
    input wire logic        sys_clk_i,
    input wire logic        rst_b_i,
    input wire logic        ce_i,
    // APB slave
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0]  pstrb_i,
    input wire logic        pready_o,
    input wire logic [31:0] prdata_o,
    input wire logic        pslverr_o,
    // Pads
    input wire logic [7:0]  pin_b_oe_b_o,
    input wire logic [7:0]  pin_b_pu_o,
    input wire logic [2:0]  pin_c_oe_b_o,
    input wire logic [3:0]  pin_c_pu_o,
    input wire logic [7:0]  pin_d_o,
    input wire logic [7:0]  pin_d_oe_b_o,
    input wire logic [7:0]  pin_d_pu_o
);
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // Edge at which a byte write commits
    wire logic wr_go = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0] && ce_i;

    property p_ready_one; pready_o |=> !pready_o; endproperty
    a_ready_one: assert property (p_ready_one) else $error("pready held too long");
    property p_ready_due; psel_i && penable_i && !pready_o && ce_i |=> pready_o; endproperty
    a_ready_due: assert property (p_ready_due) else $error("pready late");
    property p_err_zero; pslverr_o |-> pready_o && prdata_o == 32'h0; endproperty
    a_err_zero: assert property (p_err_zero) else $error("error answer malformed");
    property p_b_pull; (pin_b_pu_o & ~pin_b_oe_b_o) == 8'h00; endproperty
    a_b_pull: assert property (p_b_pull) else $error("port b pull-up on driven pin");
    property p_c_pull; (pin_c_pu_o[2:0] & ~pin_c_oe_b_o) == 3'h0; endproperty
    a_c_pull: assert property (p_c_pull) else $error("port c pull-up on driven pin");
    property p_rst_clear;
        $rose(rst_b_i) |-> pin_b_oe_b_o == 8'hff && pin_c_oe_b_o == 3'h7 && pin_d_oe_b_o == 8'hff
            && (pin_b_pu_o | pin_d_pu_o) == 8'h00 && pin_c_pu_o == 4'h0;
    endproperty
    a_rst_clear: assert property (p_rst_clear) else $error("pads not cleared by reset");
    property p_d_dir; wr_go && paddr_i == {GPBCD_IDX_D_DIR, 2'b00} |=> pin_d_oe_b_o == ~$past(pwdata_i[7:0]);
    endproperty
    a_d_dir: assert property (p_d_dir) else $error("port d output enable wrong");
    property p_c_dir; wr_go && paddr_i == {GPBCD_IDX_C_DIR, 2'b00} |=> pin_c_oe_b_o == ~$past(pwdata_i[2:0]);
    endproperty
    a_c_dir: assert property (p_c_dir) else $error("port c output enable wrong");
    property p_d_drive; wr_go && paddr_i == {GPBCD_IDX_D_DATA, 2'b00} |=> pin_d_o == $past(pwdata_i[7:0]);
    endproperty
    a_d_drive: assert property (p_d_drive) else $error("port d latch not driven");
    property p_d_pull;
        wr_go && paddr_i == {GPBCD_IDX_D_PUE, 2'b00} |=> pin_d_pu_o == ($past(pwdata_i[7:0]) & pin_d_oe_b_o);
    endproperty
    a_d_pull: assert property (p_d_pull) else $error("port d pull-up wrong");
    property p_d_hold; !wr_go |=> $stable(pin_d_oe_b_o); endproperty
    a_d_hold: assert property (p_d_hold) else $error("port d enable changed unasked");

    // Main scenarios reached
    c_dir: cover property (wr_go && paddr_i == {GPBCD_IDX_D_DIR, 2'b00});
    c_err: cover property (pslverr_o);
    c_rst: cover property ($rose(rst_b_i));
endmodule // gpbcd_properties

bind gpbcd_top gpbcd_properties i_gpbcd_properties (.*);

// >>> gpbcd_top.sv
// Port B pull-up, port B data/direction, port C and port D general-purpose I/O with APB slave
//
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
//
// Functional notes
// RULE_01: Pull-up connects only when its enable bit is 1 and direction is input.
// RULE_02: Output direction forces that pin's pull-up off, whatever the enable holds.
// RULE_03: Enable bit 0 keeps pull-up off in every direction setting.
// RULE_04: Port C is 4 bits; bit 3 input only, bits 2..0 bidirectional.
// RULE_05: Port C data bit 3 reads live pin level; writes ignored.
// RULE_06: Port C latch bits 2..0 are read/write and untouched by reset.
// RULE_07: Port D is 8 bidirectional bits; latch read/write, untouched by reset.
// RULE_08: Direction 1 enables output buffer from latch; 0 makes pin input.
// RULE_09: Reset clears port C direction bits 2..0.
// RULE_10: Reset clears all eight port D direction bits.
// RULE_11: Port C data read gives latch where output, pin where input.
// RULE_12: Port D data read gives latch where output, pin where input.
// RULE_13: Data writes always update latch; input reads still show pin.
// RULE_14: Software loads latch before setting direction bit, avoiding glitches.
// RULE_15: Port C has four pull-up enable bits, including input-only pin.
// RULE_16: Ports B and D have eight read/write pull-up enable bits each.
// RULE_17: Port B data read gives latch where output, pin where input.
// RULE_18: Reset clears all eight port B direction bits.
// RULE_19: Reset clears every pull-up enable bit.
// RULE_20: Unused port C upper bits read zero and ignore writes.
//
module gpbcd_top
    import gpbcd_pkg::*;
(
    // Clock, reset and enable
    input  wire logic        sys_clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        ce_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic             pready_o,
    output logic [31:0]      prdata_o,
    output logic             pslverr_o,
    // Port B pins
    input  wire logic [7:0]  pin_b_i,
    output logic [7:0]       pin_b_o,
    output logic [7:0]       pin_b_oe_b_o,
    output logic [7:0]       pin_b_pu_o,
    // Port C pins
    input  wire logic [3:0]  pin_c_i,
    output logic [2:0]       pin_c_o,
    output logic [2:0]       pin_c_oe_b_o,
    output logic [3:0]       pin_c_pu_o,
    // Port D pins
    input  wire logic [7:0]  pin_d_i,
    output logic [7:0]       pin_d_o,
    output logic [7:0]       pin_d_oe_b_o,
    output logic [7:0]       pin_d_pu_o
);

    // ------------------------------------------------------------
    // Read selection shared by all three ports
    // ------------------------------------------------------------
    function automatic logic [7:0] gpbcd_rd_mux(
        input logic [7:0] lat,
        input logic [7:0] dir,
        input logic [7:0] pin
    );
        return (lat & dir) | (pin & ~dir);
    endfunction

    // Pull-up is on only for an enabled bit whose pin is an input
    function automatic logic [7:0] gpbcd_pull(
        input logic [7:0] pue,
        input logic [7:0] dir
    );
        return pue & ~dir;
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [GPBCD_PIN_BITS-1:0]  pin_s1_q;
    logic [GPBCD_PIN_BITS-1:0]  pin_s2_q;
    logic [7:0]                 lat_b_q;
    logic [7:0]                 lat_b_d;
    logic [GPBCD_C_IO_BITS-1:0] lat_c_q;
    logic [GPBCD_C_IO_BITS-1:0] lat_c_d;
    logic [7:0]                 lat_d_q;
    logic [7:0]                 lat_d_d;
    gpbcd_cfg_type              cfg_b_q;
    gpbcd_cfg_type              cfg_b_d;
    gpbcd_cfg_type              cfg_c_q;
    gpbcd_cfg_type              cfg_c_d;
    gpbcd_cfg_type              cfg_d_q;
    gpbcd_cfg_type              cfg_d_d;
    gpbcd_pad_type              pad_b_q;
    gpbcd_pad_type              pad_b_d;
    gpbcd_pad_type              pad_c_q;
    gpbcd_pad_type              pad_c_d;
    gpbcd_pad_type              pad_d_q;
    gpbcd_pad_type              pad_d_d;
    logic [7:0]                 drv_b_q;
    logic [GPBCD_C_IO_BITS-1:0] drv_c_q;
    logic [7:0]                 drv_d_q;
    logic                       pready_q;
    logic                       pready_d;
    logic [31:0]                prdata_q;
    logic [31:0]                prdata_d;
    logic                       pslverr_q;
    logic                       pslverr_d;

    // ------------------------------------------------------------
    // Synchronised pin levels
    // ------------------------------------------------------------
    wire logic [7:0] pin_b_s = pin_s2_q[7:0];
    wire logic [3:0] pin_c_s = pin_s2_q[11:8];
    wire logic [7:0] pin_d_s = pin_s2_q[19:12];

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic [5:0] idx       = paddr_i[7:2];
    wire logic       aligned   = (paddr_i[1:0] == 2'b00);
    wire logic       hit_b_dat = aligned & (idx == GPBCD_IDX_B_DATA);
    wire logic       hit_c_dat = aligned & (idx == GPBCD_IDX_C_DATA);
    wire logic       hit_d_dat = aligned & (idx == GPBCD_IDX_D_DATA);
    wire logic       hit_b_dir = aligned & (idx == GPBCD_IDX_B_DIR);
    wire logic       hit_c_dir = aligned & (idx == GPBCD_IDX_C_DIR);
    wire logic       hit_d_dir = aligned & (idx == GPBCD_IDX_D_DIR);
    wire logic       hit_b_pue = aligned & (idx == GPBCD_IDX_B_PUE);
    wire logic       hit_c_pue = aligned & (idx == GPBCD_IDX_C_PUE);
    wire logic       hit_d_pue = aligned & (idx == GPBCD_IDX_D_PUE);
    wire logic       mapped    = hit_b_dat | hit_c_dat | hit_d_dat
                               | hit_b_dir | hit_c_dir | hit_d_dir
                               | hit_b_pue | hit_c_pue | hit_d_pue;

    // First access cycle prepares the answer, second one completes it
    wire logic acc_first = psel_i & penable_i & ~pready_q;
    wire logic acc_done  = psel_i & penable_i & pready_q;
    wire logic wr_en     = acc_done & pwrite_i & pstrb_i[0];
    wire logic [7:0] wbyte = pwdata_i[7:0];

    // ------------------------------------------------------------
    // Data latch next values
    // ------------------------------------------------------------
    // Latches take a write whatever the direction
    assign lat_b_d = (wr_en & hit_b_dat) ? wbyte : lat_b_q;                          // [RULE_13]
    assign lat_c_d = (wr_en & hit_c_dat) ? wbyte[GPBCD_C_IO_BITS-1:0] : lat_c_q;     // [RULE_05] [RULE_06]
    assign lat_d_d = (wr_en & hit_d_dat) ? wbyte : lat_d_q;                          // [RULE_07] [RULE_13]

    // ------------------------------------------------------------
    // Direction and pull-up enable next values
    // ------------------------------------------------------------
    // Port B, full width
    assign cfg_b_d.dir = (wr_en & hit_b_dir) ? wbyte : cfg_b_q.dir;
    assign cfg_b_d.pue = (wr_en & hit_b_pue) ? wbyte : cfg_b_q.pue;                  // [RULE_16]

    // Port C: bit 3 has no direction, upper bits stay zero
    assign cfg_c_d.dir = (wr_en & hit_c_dir) ? {5'h00, wbyte[2:0]} : cfg_c_q.dir;    // [RULE_04] [RULE_20]
    assign cfg_c_d.pue = (wr_en & hit_c_pue) ? {4'h0, wbyte[3:0]} : cfg_c_q.pue;     // [RULE_15] [RULE_20]

    // Port D, full width
    assign cfg_d_d.dir = (wr_en & hit_d_dir) ? wbyte : cfg_d_q.dir;                  // [RULE_07]
    assign cfg_d_d.pue = (wr_en & hit_d_pue) ? wbyte : cfg_d_q.pue;                  // [RULE_16]

    // ------------------------------------------------------------
    // Pad control next values, taken from next register state so
    // the pads follow a register write at the same edge
    // ------------------------------------------------------------
    assign pad_b_d.oe_b = ~cfg_b_d.dir;                                              // [RULE_08]
    assign pad_b_d.pull = gpbcd_pull(cfg_b_d.pue, cfg_b_d.dir);                      // [RULE_01] [RULE_02] [RULE_03]
    assign pad_c_d.oe_b = ~cfg_c_d.dir;                                              // [RULE_08] [RULE_04]
    assign pad_c_d.pull = gpbcd_pull(cfg_c_d.pue, cfg_c_d.dir);                      // [RULE_01] [RULE_02] [RULE_03]
    assign pad_d_d.oe_b = ~cfg_d_d.dir;                                              // [RULE_08]
    assign pad_d_d.pull = gpbcd_pull(cfg_d_d.pue, cfg_d_d.dir);                      // [RULE_01] [RULE_02] [RULE_03]

    // ------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------
    wire logic [7:0] rd_b_dat = gpbcd_rd_mux(lat_b_q, cfg_b_q.dir, pin_b_s);         // [RULE_17]
    // Port C bit 3 direction is always 0, so it always shows its pin
    wire logic [7:0] rd_c_dat = gpbcd_rd_mux({5'h00, lat_c_q}, cfg_c_q.dir,
                                             {4'h0, pin_c_s});                       // [RULE_11] [RULE_05] [RULE_20]
    wire logic [7:0] rd_d_dat = gpbcd_rd_mux(lat_d_q, cfg_d_q.dir, pin_d_s);         // [RULE_12]

    wire logic [7:0] rd_byte =
        hit_b_dat ? rd_b_dat :
        hit_c_dat ? rd_c_dat :
        hit_d_dat ? rd_d_dat :
        hit_b_dir ? cfg_b_q.dir :
        hit_c_dir ? cfg_c_q.dir :
        hit_d_dir ? cfg_d_q.dir :
        hit_b_pue ? cfg_b_q.pue :
        hit_c_pue ? cfg_c_q.pue :
        hit_d_pue ? cfg_d_q.pue :
        8'h00;

    // ------------------------------------------------------------
    // APB answer next values
    // ------------------------------------------------------------
    assign pready_d  = acc_first;
    assign prdata_d  = (acc_first & ~pwrite_i) ? {24'h000000, rd_byte} :
                       (acc_first ? 32'h00000000 : prdata_q);
    assign pslverr_d = acc_first & ~mapped;

    // ------------------------------------------------------------
    // Pin synchroniser, two stages
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pin_s1_q <= '0;
            pin_s2_q <= '0;
        end else if (ce_i) begin
            pin_s1_q <= {pin_d_i, pin_c_i, pin_b_i};
            pin_s2_q <= pin_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Data latches and drive flops, not reset
    // ------------------------------------------------------------
    // Latches keep their contents through reset
    always_ff @(posedge sys_clk_i) begin
        if (ce_i) begin
            lat_b_q <= lat_b_d;
            lat_c_q <= lat_c_d;                                                      // [RULE_06]
            lat_d_q <= lat_d_d;                                                      // [RULE_07]
        end
    end

    // Pin drive follows the latch; loading it first avoids a glitch
    always_ff @(posedge sys_clk_i) begin
        if (ce_i) begin
            drv_b_q <= lat_b_d;                                                      // [RULE_08] [RULE_14]
            drv_c_q <= lat_c_d;                                                      // [RULE_08] [RULE_14]
            drv_d_q <= lat_d_d;                                                      // [RULE_08] [RULE_14]
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cfg_b_q.dir <= GPBCD_DIR_RST;                                            // [RULE_18]
            cfg_c_q.dir <= GPBCD_DIR_RST;                                            // [RULE_09]
            cfg_d_q.dir <= GPBCD_DIR_RST;                                            // [RULE_10]
            cfg_b_q.pue <= GPBCD_PUE_RST;                                            // [RULE_19]
            cfg_c_q.pue <= GPBCD_PUE_RST;                                            // [RULE_19]
            cfg_d_q.pue <= GPBCD_PUE_RST;                                            // [RULE_19]
        end else if (ce_i) begin
            cfg_b_q <= cfg_b_d;
            cfg_c_q <= cfg_c_d;
            cfg_d_q <= cfg_d_d;
        end
    end

    // ------------------------------------------------------------
    // Pad control flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pad_b_q <= '{oe_b: GPBCD_OE_B_RST, pull: GPBCD_PULL_RST};                // [RULE_18]
            pad_c_q <= '{oe_b: GPBCD_OE_B_RST, pull: GPBCD_PULL_RST};                // [RULE_09]
            pad_d_q <= '{oe_b: GPBCD_OE_B_RST, pull: GPBCD_PULL_RST};                // [RULE_10]
        end else if (ce_i) begin
            pad_b_q <= pad_b_d;
            pad_c_q <= pad_c_d;
            pad_d_q <= pad_d_d;
        end
    end

    // ------------------------------------------------------------
    // APB answer flops
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pready_q  <= 1'b0;
            prdata_q  <= 32'h00000000;
            pslverr_q <= 1'b0;
        end else if (ce_i) begin
            pready_q  <= pready_d;
            prdata_q  <= prdata_d;
            pslverr_q <= pslverr_d;
        end
    end

    // ------------------------------------------------------------
    // Outputs, straight from flops
    // ------------------------------------------------------------
    // Bus answer
    assign pready_o     = pready_q;
    assign prdata_o     = prdata_q;
    assign pslverr_o    = pslverr_q;

    // Port B pads
    assign pin_b_o      = drv_b_q;
    assign pin_b_oe_b_o = pad_b_q.oe_b;
    assign pin_b_pu_o   = pad_b_q.pull;

    // Port C pads; bit 3 has no driver at all
    assign pin_c_o      = drv_c_q;                                                   // [RULE_04]
    assign pin_c_oe_b_o = pad_c_q.oe_b[GPBCD_C_IO_BITS-1:0];
    assign pin_c_pu_o   = pad_c_q.pull[GPBCD_C_BITS-1:0];                            // [RULE_15]

    // Port D pads
    assign pin_d_o      = drv_d_q;
    assign pin_d_oe_b_o = pad_d_q.oe_b;
    assign pin_d_pu_o   = pad_d_q.pull;

endmodule // gpbcd_top

// >>> tb_top.sv
// Self-checking bench for the port B/C/D block over APB
`timescale 1ns/1ps
module tb_top;
    import gpbcd_pkg::*;
    // ------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------
    logic        sys_clk, rst_b, ce, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, b_i, b_o, b_oe, b_pu, d_i, d_o, d_oe, d_pu, eb_en, eb_val, ed_en, ed_val;
    logic [31:0] pwdata, prdata;
    logic [3:0]  pstrb, c_i, c_pu, ec_en, ec_val;
    logic [2:0]  c_o, c_oe;
    int          n_mismatch = 0;
    int          n_checks = 0;

    gpbcd_top i_gpbcd_top (.sys_clk_i(sys_clk), .rst_b_i(rst_b), .ce_i(ce), .psel_i(psel),
        .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb),
        .pready_o(pready), .prdata_o(prdata), .pslverr_o(pslverr), .pin_b_i(b_i), .pin_b_o(b_o),
        .pin_b_oe_b_o(b_oe), .pin_b_pu_o(b_pu), .pin_c_i(c_i), .pin_c_o(c_o), .pin_c_oe_b_o(c_oe),
        .pin_c_pu_o(c_pu), .pin_d_i(d_i), .pin_d_o(d_o), .pin_d_oe_b_o(d_oe), .pin_d_pu_o(d_pu));
    gpbcd_board #(.W(8)) i_gpbcd_board_b (.clk_i(sys_clk), .drv_i(b_o), .oe_b_i(b_oe), .pu_i(b_pu),
        .ext_en_i(eb_en), .ext_val_i(eb_val), .lvl_o(b_i));
    gpbcd_board #(.W(4)) i_gpbcd_board_c (.clk_i(sys_clk), .drv_i({1'b0, c_o}), .oe_b_i({1'b1, c_oe}),
        .pu_i(c_pu), .ext_en_i(ec_en), .ext_val_i(ec_val), .lvl_o(c_i));
    gpbcd_board #(.W(8)) i_gpbcd_board_d (.clk_i(sys_clk), .drv_i(d_o), .oe_b_i(d_oe), .pu_i(d_pu),
        .ext_en_i(ed_en), .ext_val_i(ed_val), .lvl_o(d_i));

    // Clock at 200 MHz
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    function automatic logic [7:0] ad(input logic [5:0] idx);
        return {idx, 2'b00};
    endfunction
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // One APB transfer, then one idle cycle
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [3:0] st,
                       output logic [31:0] rd, output logic er);
        psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= wd; pstrb <= st;
        @(posedge sys_clk);
        penable <= 1'b1;
        // The wait ends on pready; only the watchdog bounds it
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, a, {24'h0, d}, 4'hf, r, e);
    endtask
    task automatic rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, 4'hf, r, e);
        chk(nm, {24'h0, exp}, r);
        chk({nm, " err"}, 32'h0, {31'h0, e});
    endtask
    task automatic settle;
        repeat (6) @(posedge sys_clk);
    endtask
    task automatic test_end(input string s);
        $display("test %s done", s);
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (5000) @(posedge sys_clk);
        chk("watchdog", 32'h0, 32'h1);
        wrap_up;
    end

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic [31:0] r;
        logic        e;
        rst_b = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00; pwdata = 32'h0; pstrb = 4'h0;
        eb_en = 8'h00; eb_val = 8'h00; ec_en = 4'h0; ec_val = 4'h0; ed_en = 8'h00; ed_val = 8'h00; ce = 1'b1;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        @(posedge sys_clk);
        rd("b dir", ad(GPBCD_IDX_B_DIR), 8'h00);
        rd("c dir", ad(GPBCD_IDX_C_DIR), 8'h00);
        rd("d dir", ad(GPBCD_IDX_D_DIR), 8'h00);
        rd("d pue", ad(GPBCD_IDX_D_PUE), 8'h00);
        test_end("reset");
        eb_en <= 8'hf0; eb_val <= 8'ha5;
        wr(ad(GPBCD_IDX_B_PUE), 8'ha5);
        wr(ad(GPBCD_IDX_C_PUE), 8'hff);
        wr(ad(GPBCD_IDX_D_PUE), 8'h3c);
        rd("b pue", ad(GPBCD_IDX_B_PUE), 8'ha5);
        rd("c pue", ad(GPBCD_IDX_C_PUE), 8'h0f);
        chk("b pu", 32'ha5, 32'(b_pu));
        wr(ad(GPBCD_IDX_B_DATA), 8'h3c);
        wr(ad(GPBCD_IDX_B_DIR), 8'h0f);
        settle;
        chk("b pu out", 32'ha0, 32'(b_pu));
        chk("b oe_b", 32'hf0, 32'(b_oe));
        chk("b drive", 32'h3c, 32'(b_o));
        rd("b mix", ad(GPBCD_IDX_B_DATA), 8'hac);
        test_end("port b");
        ed_en <= 8'hff; ed_val <= 8'h5a;
        wr(ad(GPBCD_IDX_D_DATA), 8'hff);
        settle;
        rd("d in", ad(GPBCD_IDX_D_DATA), 8'h5a);
        ed_en <= 8'h0f;
        wr(ad(GPBCD_IDX_D_DIR), 8'hf0);
        settle;
        rd("d mix", ad(GPBCD_IDX_D_DATA), 8'hfa);
        chk("d oe_b", 32'h0f, 32'(d_oe));
        chk("d pu", 32'h0c, 32'(d_pu));
        test_end("port d");
        ec_en <= 4'hf; ec_val <= 4'ha;
        wr(ad(GPBCD_IDX_C_DATA), 8'hff);
        settle;
        rd("c in", ad(GPBCD_IDX_C_DATA), 8'h0a);
        ec_en <= 4'h8; ec_val <= 4'h0;
        wr(ad(GPBCD_IDX_C_DIR), 8'hff);
        settle;
        rd("c dir out", ad(GPBCD_IDX_C_DIR), 8'h07);
        rd("c out", ad(GPBCD_IDX_C_DATA), 8'h07);
        chk("c pu", 32'h8, 32'(c_pu));
        chk("c drive", 32'h7, 32'(c_o));
        ec_val <= 4'h8;
        settle;
        rd("c pin3", ad(GPBCD_IDX_C_DATA), 8'h0f);
        test_end("port c");
        apb(1'b0, 8'h30, 32'h0, 4'hf, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        apb(1'b0, 8'h0d, 32'h0, 4'hf, r, e);
        chk("misaligned err", 32'h1, {31'h0, e});
        apb(1'b1, ad(GPBCD_IDX_D_PUE), 32'hff, 4'h0, r, e);
        rd("d pue strb", ad(GPBCD_IDX_D_PUE), 8'h3c);
        test_end("refusals");
        ed_en <= 8'h00;
        rst_b <= 1'b0;
        ce <= 1'b0;
        repeat (10) @(posedge sys_clk);
        rst_b <= 1'b1;
        ce <= 1'b1;
        @(posedge sys_clk);
        chk("d oe_b rst", 32'hff, 32'(d_oe));
        wr(ad(GPBCD_IDX_D_DIR), 8'hff);
        wr(ad(GPBCD_IDX_C_DIR), 8'h07);
        settle;
        rd("d kept", ad(GPBCD_IDX_D_DATA), 8'hff);
        rd("c kept", ad(GPBCD_IDX_C_DATA), 8'h0f);
        test_end("second reset");
        wrap_up;
    end
endmodule // tb_top
